// ==== design/bus_cmd_decoder.sv ====
// Purpose: classify handshaken bus bytes and keep interface state
// Assumes: handshake engine delivers BYTE_STB_I with byte and pins
// Notes: bus pins are active low; outputs are active high except SRQ_B_O and EOI_B_O
`timescale 1ns/10ps
`default_nettype none
module bus_cmd_decoder
  import bus_cmd_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic BYTE_STB_I,
  input wire logic [7:0] DIO_B_I,
  input wire logic EOI_B_I,
  input wire logic ATN_B_I,
  input wire logic IFC_B_I,
  input wire logic REN_B_I,
  input wire logic [ADDR_W-1:0] PRIMARY_ADDR_I,
  input wire logic SERVICE_NEED_I,
  input wire logic TX_LAST_I,
  output logic DATA_VALID_O,
  output logic [7:0] DATA_O,
  output logic DATA_LAST_O,
  output logic LISTEN_O,
  output logic TALK_O,
  output logic REMOTE_O,
  output logic LOCKOUT_O,
  output logic POLL_MODE_O,
  output logic TRIGGER_O,
  output logic CLEAR_O,
  output logic SRQ_B_O,
  output logic SRQ_OE_O,
  output logic EOI_B_O,
  output logic EOI_OE_O
);
  // ==========================================================
  // Uniline synchronisers
  // ==========================================================
  logic ifc_b_s;
  logic ren_b_s;
  pin_sync u_ifc (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .rst_val_i(1'b1),
    .pin_i(IFC_B_I),
    .level_o(ifc_b_s)
  );
  pin_sync u_ren (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .rst_val_i(1'b1),
    .pin_i(REN_B_I),
    .level_o(ren_b_s)
  );

  // ==========================================================
  // Byte decode
  // ==========================================================
  logic [7:0] byte_t;
  logic [6:0] cmd;
  logic [1:0] grp;
  logic atn;
  logic is_cmd;
  logic is_data;
  logic [6:0] my_listen;
  logic [6:0] my_talk;
  assign byte_t = ~DIO_B_I;
  assign cmd = byte_t[6:0];
  assign grp = cmd[6:5];
  assign atn = ~ATN_B_I;
  assign is_cmd = BYTE_STB_I && atn;
  assign is_data = BYTE_STB_I && !atn;
  assign my_listen = {GRP_LISTEN, PRIMARY_ADDR_I};
  assign my_talk = {GRP_TALK, PRIMARY_ADDR_I};

  // ==========================================================
  // Interface state
  // ==========================================================
  logic listen_q, listen_d;
  logic talk_q, talk_d;
  logic remote_q, remote_d;
  logic lock_q, lock_d;
  logic poll_q, poll_d;
  logic trig_q, trig_d;
  logic clr_q, clr_d;
  logic dv_q, dv_d;
  logic [7:0] data_q, data_d;
  logic last_q, last_d;

  always_comb begin
    listen_d = listen_q;
    talk_d = talk_q;
    remote_d = remote_q;
    lock_d = lock_q;
    poll_d = poll_q;
    trig_d = 1'b0;
    clr_d = 1'b0;
    dv_d = is_data;
    data_d = is_data ? byte_t : data_q;
    last_d = is_data ? ~EOI_B_I : last_q;
    if (is_cmd) begin
      unique case (grp)
        GRP_UNIV: begin
          if (cmd == CMD_LOCKOUT) begin
            lock_d = 1'b1;
          end else if (cmd == CMD_DEV_CLEAR) begin
            clr_d = 1'b1;
          end else if (cmd == CMD_POLL_EN) begin
            poll_d = 1'b1;
          end else if (cmd == CMD_POLL_DIS) begin
            poll_d = 1'b0;
          end else if (listen_q) begin
            if (cmd == CMD_SEL_CLEAR) begin
              clr_d = 1'b1;
            end else if (cmd == CMD_GO_LOCAL) begin
              remote_d = 1'b0;
              lock_d = 1'b0;
            end else if (cmd == CMD_TRIGGER) begin
              trig_d = 1'b1;
            end
          end
          // poll config and take control ignored
        end
        GRP_LISTEN: begin
          if (cmd == CMD_UNLISTEN) begin
            listen_d = 1'b0;
          end else if (cmd == my_listen) begin
            listen_d = 1'b1;
          end
        end
        GRP_TALK: begin
          if (cmd == CMD_UNTALK) begin
            talk_d = 1'b0;
          end else begin
            // own talk address, other clears us
            talk_d = (cmd == my_talk);
          end
        end
        GRP_SECOND: begin
        end
      endcase
    end
    if (clr_d) begin
      poll_d = 1'b0;
    end
    if (!ren_b_s) begin
      if (is_cmd && cmd == my_listen) begin
        remote_d = 1'b1;
      end
    end else begin
      remote_d = 1'b0;
      lock_d = 1'b0;
    end
    if (!ifc_b_s) begin
      listen_d = 1'b0;
      talk_d = 1'b0;
      poll_d = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
      remote_q <= 1'b0;
      lock_q <= 1'b0;
      poll_q <= 1'b0;
      trig_q <= 1'b0;
      clr_q <= 1'b0;
      dv_q <= 1'b0;
      data_q <= 8'h00;
      last_q <= 1'b0;
    end else begin
      listen_q <= listen_d;
      talk_q <= talk_d;
      remote_q <= remote_d;
      lock_q <= lock_d;
      poll_q <= poll_d;
      trig_q <= trig_d;
      clr_q <= clr_d;
      dv_q <= dv_d;
      data_q <= data_d;
      last_q <= last_d;
    end
  end

  // ==========================================================
  // Service request and end marker drivers
  // ==========================================================
  // request held while need stands
  assign SRQ_OE_O = SERVICE_NEED_I;
  assign SRQ_B_O = ~SERVICE_NEED_I;
  // end marker with last sent byte
  assign EOI_OE_O = talk_q && TX_LAST_I;
  assign EOI_B_O = ~(talk_q && TX_LAST_I);
  // attention, clear and remote are inputs only

  assign DATA_VALID_O = dv_q;
  assign DATA_O = data_q;
  assign DATA_LAST_O = last_q;
  assign LISTEN_O = listen_q;
  assign TALK_O = talk_q;
  assign REMOTE_O = remote_q;
  assign LOCKOUT_O = lock_q;
  assign POLL_MODE_O = poll_q;
  assign TRIGGER_O = trig_q;
  assign CLEAR_O = clr_q;

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_my_listen;
    is_cmd && cmd == my_listen && cmd != CMD_UNLISTEN && ifc_b_s;
  endsequence
  sequence s_my_talk;
    is_cmd && cmd == my_talk && cmd != CMD_UNTALK && ifc_b_s;
  endsequence
  property p_cmd_not_data;
    @(posedge MCLK_I) disable iff (!RST_B_I)
      is_cmd |=> !DATA_VALID_O && $stable(DATA_O);
  endproperty
  a_cmd_not_data: assert property (p_cmd_not_data) else
    $error("command byte leaked as data");
  property p_data_pass;
    @(posedge MCLK_I) disable iff (!RST_B_I)
      is_data |=> DATA_VALID_O && DATA_O == $past(byte_t);
  endproperty
  a_data_pass: assert property (p_data_pass) else
    $error("data byte not passed");
  property p_listen;
    @(posedge MCLK_I) disable iff (!RST_B_I) s_my_listen |=> LISTEN_O;
  endproperty
  a_listen: assert property (p_listen) else
    $error("listen address missed");
  property p_talk;
    @(posedge MCLK_I) disable iff (!RST_B_I) s_my_talk |=> TALK_O;
  endproperty
  a_talk: assert property (p_talk) else
    $error("talk address missed");
  property p_unl;
    @(posedge MCLK_I) disable iff (!RST_B_I)
      is_cmd && cmd == CMD_UNLISTEN |=> !LISTEN_O;
  endproperty
  a_unl: assert property (p_unl) else
    $error("unlisten ignored");
  property p_unt;
    @(posedge MCLK_I) disable iff (!RST_B_I)
      is_cmd && cmd == CMD_UNTALK |=> !TALK_O;
  endproperty
  a_unt: assert property (p_unt) else
    $error("untalk ignored");
  property p_trig_addr;
    @(posedge MCLK_I) disable iff (!RST_B_I)
      TRIGGER_O |-> $past(listen_q) && $past(is_cmd);
  endproperty
  a_trig_addr: assert property (p_trig_addr) else
    $error("trigger without listen");
  property p_ifc;
    @(posedge MCLK_I) disable iff (!RST_B_I)
      !ifc_b_s |=> !LISTEN_O && !TALK_O;
  endproperty
  a_ifc: assert property (p_ifc) else
    $error("interface clear ignored");
  property p_srq;
    @(posedge MCLK_I) disable iff (!RST_B_I)
      SERVICE_NEED_I |-> SRQ_OE_O && !SRQ_B_O;
  endproperty
  a_srq: assert property (p_srq) else
    $error("service request not driven");
endmodule // bus_cmd_decoder
`default_nettype wire

// ==== design/bus_cmd_pkg.sv ====
// Purpose: shared constants for the bus command decoder
// Assumes: 8-bit command bytes, bit 7 ignored under attention
// Notes: all bus pins are active low at the pins
package bus_cmd_pkg;
  localparam logic [6:0] CMD_GO_LOCAL = 7'h01;
  localparam logic [6:0] CMD_SEL_CLEAR = 7'h04;
  localparam logic [6:0] CMD_TRIGGER = 7'h08;
  localparam logic [6:0] CMD_LOCKOUT = 7'h11;
  localparam logic [6:0] CMD_DEV_CLEAR = 7'h14;
  localparam logic [6:0] CMD_POLL_EN = 7'h18;
  localparam logic [6:0] CMD_POLL_DIS = 7'h19;
  localparam logic [6:0] CMD_UNLISTEN = 7'h3f;
  localparam logic [6:0] CMD_UNTALK = 7'h5f;
  localparam logic [1:0] GRP_UNIV = 2'h0;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SECOND = 2'h3;
  localparam int ADDR_W = 5;
  localparam int SYNC_N = 3;
endpackage

// ==== design/pin_sync.sv ====
// Purpose: three-stage synchroniser for one asynchronous pin
// Assumes: output changes only when stages two and three agree
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import bus_cmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic rst_val_i,
  input wire logic pin_i,
  output logic level_o
);
  logic [SYNC_N-1:0] st_q;
  logic [SYNC_N-1:0] st_d;
  logic lvl_q;
  logic lvl_d;

  always_comb begin
    st_d = {st_q[SYNC_N-2:0], pin_i};
    lvl_d = (st_q[1] == st_q[2]) ? st_q[2] : lvl_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q <= {SYNC_N{rst_val_i}};
      lvl_q <= rst_val_i;
    end else begin
      st_q <= st_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;
endmodule // pin_sync
`default_nettype wire

// ==== testbench/bus_ctl_model.sv ====
// ==========================================================
// Purpose: active controller model driving bytes and lines
// Assumes: bus lines pulled up, so released lines read high
// Notes: strobe stands in for the handshake engine accept
`timescale 1ns/10ps
`default_nettype none
module bus_ctl_model (
  input wire logic clk_i,
  output logic stb_o,
  output logic [7:0] dio_b_o,
  output logic atn_b_o,
  output logic eoi_b_o,
  output logic ifc_b_o,
  output logic ren_b_o
);
  // controller owns management lines, low true
  initial begin
    stb_o = 1'b0;
    dio_b_o = 8'hff;
    atn_b_o = 1'b1;
    eoi_b_o = 1'b1;
    ifc_b_o = 1'b1;
    ren_b_o = 1'b1;
  end

  // one accepted byte, then data and end released
  task automatic put(input logic atn, input logic [7:0] b,
                     input logic eoi);
    @(posedge clk_i);
    stb_o <= 1'b1;
    dio_b_o <= ~b;
    atn_b_o <= ~atn;
    eoi_b_o <= ~eoi;
    @(posedge clk_i);
    stb_o <= 1'b0;
    dio_b_o <= 8'hff;
    eoi_b_o <= 1'b1;
  endtask

  task automatic lines(input logic ifc, input logic ren);
    @(posedge clk_i);
    ifc_b_o <= ~ifc;
    ren_b_o <= ~ren;
  endtask
endmodule // bus_ctl_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// ==========================================================
// Purpose: self-checking bench for the bus command decoder
// Assumes: own primary address 16 (later 3), listen 30h, talk 50h
// Notes: state word is {dv,trig,clr,listen,talk,rem,lock,poll}
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk, rst_b, stb, atn_b, eoi_b, ifc_b, ren_b;
  logic need, tx_last, dv, last, lsn, tlk, rem, lck, pol, trg, clr;
  logic srq_b, srq_oe, eoi_o, eoi_oe;
  logic [7:0] dio_b, dout, st;
  logic [4:0] addr;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] ign [6] = '{8'h60, 8'h7f, 8'h05, 8'h15, 8'h09, 8'he2};
  assign st = {dv, trg, clr, lsn, tlk, rem, lck, pol};

  bus_ctl_model u_ctl (.clk_i(mclk), .stb_o(stb), .dio_b_o(dio_b),
    .atn_b_o(atn_b), .eoi_b_o(eoi_b), .ifc_b_o(ifc_b), .ren_b_o(ren_b));

  bus_cmd_decoder u_dut (.MCLK_I(mclk), .RST_B_I(rst_b),
    .BYTE_STB_I(stb), .DIO_B_I(dio_b), .EOI_B_I(eoi_b),
    .ATN_B_I(atn_b), .IFC_B_I(ifc_b), .REN_B_I(ren_b),
    .PRIMARY_ADDR_I(addr), .SERVICE_NEED_I(need),
    .TX_LAST_I(tx_last), .DATA_VALID_O(dv), .DATA_O(dout),
    .DATA_LAST_O(last), .LISTEN_O(lsn), .TALK_O(tlk),
    .REMOTE_O(rem), .LOCKOUT_O(lck), .POLL_MODE_O(pol),
    .TRIGGER_O(trg), .CLEAR_O(clr), .SRQ_B_O(srq_b),
    .SRQ_OE_O(srq_oe), .EOI_B_O(eoi_o), .EOI_OE_O(eoi_oe));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ========================================================
  // Compare and drive helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic pc(input logic [7:0] b, input logic [7:0] e);
    u_ctl.put(1'b1, b, 1'b0);
    #1;
    chk(st, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ========================================================
  // Scenarios
  task automatic t_addr;
    pc(8'h30, 8'h10);
    pc(8'h31, 8'h10);
    pc(8'h50, 8'h18);
    pc(8'h45, 8'h10);
    pc(8'h50, 8'h18);
    pc(8'h5f, 8'h10);
    pc(8'h3f, 8'h00);
  endtask

  task automatic t_addressed;
    pc(8'h08, 8'h00);
    pc(8'h04, 8'h00);
    pc(8'h30, 8'h10);
    pc(8'h08, 8'h50);
    pc(8'h04, 8'h30);
  endtask

  task automatic t_universal;
    pc(8'h18, 8'h11);
    pc(8'h19, 8'h10);
    pc(8'h18, 8'h11);
    pc(8'h14, 8'h30);
    u_ctl.lines(1'b0, 1'b1);
    wt(6);
    pc(8'h11, 8'h12);
  endtask

  task automatic t_ignore;
    foreach (ign[i]) pc(ign[i], 8'h12);
  endtask

  task automatic t_remote;
    pc(8'h30, 8'h16);
    pc(8'h01, 8'h10);
    pc(8'h30, 8'h14);
    u_ctl.lines(1'b0, 1'b0);
    wt(6);
    chk(st, 8'h10);
  endtask

  task automatic t_data;
    u_ctl.put(1'b0, 8'h2a, 1'b0);
    #1;
    chk(st, 8'h90);
    chk(dout, 8'h2a);
    u_ctl.put(1'b0, 8'h54, 1'b1);
    #1;
    chk({dout[6:0], last}, {7'h54, 1'b1});
  endtask

  task automatic t_drive;
    pc(8'h50, 8'h18);
    @(posedge mclk);
    need <= 1'b1;
    tx_last <= 1'b1;
    wt(1);
    chk({4'h0, srq_b, srq_oe, eoi_o, eoi_oe}, 8'h05);
    @(posedge mclk);
    need <= 1'b0;
    tx_last <= 1'b0;
    wt(1);
    chk({7'h0, srq_oe | eoi_oe}, 8'h00);
    pc(8'h5f, 8'h10);
    @(posedge mclk);
    tx_last <= 1'b1;
    wt(1);
    chk({6'h0, eoi_o, eoi_oe}, 8'h02);
    @(posedge mclk);
    tx_last <= 1'b0;
  endtask

  task automatic t_addr_cfg;
    @(posedge mclk);
    addr <= 5'h03;
    pc(8'h3f, 8'h00);
    pc(8'h23, 8'h10);
    pc(8'h43, 8'h18);
    pc(8'h50, 8'h10);
  endtask

  task automatic t_ifc;
    u_ctl.lines(1'b1, 1'b0);
    wt(6);
    chk(st, 8'h00);
    u_ctl.lines(1'b0, 1'b0);
    wt(6);
  endtask

  // ========================================================
  // Main sequence and hang guard
  initial begin
    rst_b = 1'b0;
    need = 1'b0;
    tx_last = 1'b0;
    addr = 5'h10;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    wt(4);
    chk(st, 8'h00);
    t_addr();
    t_addressed();
    t_universal();
    t_ignore();
    t_remote();
    t_data();
    t_drive();
    t_addr_cfg();
    t_ifc();
    end_sim();
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      end_sim();
    end
  end
endmodule // tb_top
`default_nettype wire
